// >>> gpio_port_slice.sv
/*
 * One 8-bit port slice: stored pin data, per-pin mode decode, two-stage
 * input synchroniser and read-back select.
 * Assumes writes arrive as a one-cycle strobe with byte data.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_port_slice
   import gpio_ports_pkg::*;
#(
   parameter logic [7:0] OUT_ALLOWED = 8'hFF  // Pins that may drive
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic [15:0] mode_i,
   input  wire logic [7:0]  pin_i,
   output logic      [7:0]  rdata_o,
   output logic      [7:0]  pin_o,
   output logic      [7:0]  pin_oe_o,
   output logic      [7:0]  pullup_en_o
);

   // =======================================================================
   // Storage
   logic [7:0] data_q;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [7:0] drive_oe_d;
   logic [7:0] pull_d;
   logic [7:0] rsel_d;

   // Pin data register, written regardless of mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_q <= PIN_DATA_RESET;               // see (R2)
      end else if (ce_i && wr_i) begin
         data_q <= wdata_i;                      // see (R1) see (R3)
      end
   end

   // Two-stage synchroniser for pin levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= PIN_DATA_RESET;
         sync2_q <= PIN_DATA_RESET;
      end else if (ce_i) begin
         sync1_q <= pin_i;                       // see (R10)
         sync2_q <= sync1_q;
      end
   end

   // Per-pin mode decode
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         drive_oe_d[n] = (mode_i[2*n +: 2] == MODE_OUTPUT) && OUT_ALLOWED[n]; // see (R4) see (R8)
         pull_d[n]     = (mode_i[2*n +: 2] == MODE_INPUT_PULLUP);              // see (R5) see (R6)
         rsel_d[n]     = mode_i[2*n + 1];        // Input modes read the pin
      end
   end

   // Registered pin and read-back outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o       <= PIN_DATA_RESET;
         pin_oe_o    <= PIN_DATA_RESET;
         pullup_en_o <= PIN_DATA_RESET;
         rdata_o     <= PIN_DATA_RESET;
      end else if (ce_i) begin
         pin_o       <= data_q;
         pin_oe_o    <= drive_oe_d;              // see (R4)
         pullup_en_o <= pull_d;                  // see (R5) see (R6)
         rdata_o     <= (sync2_q & rsel_d) | (data_q & ~rsel_d); // see (R3) see (R5)
      end
   end

endmodule : gpio_port_slice

`default_nettype wire

// >>> gpio_ports.sv
/*
 * Multi-port pin data registers: five 8-bit bidirectional ports (A to E)
 * and one 8-bit input-only port (F), with per-port function control
 * registers, all behind a classic Wishbone slave.
 * Assumes synchronous inputs, a 20 MHz clk_i and synchronous active-high reset.
 */
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
// Behaviour
// (R1) Each port data register is 8 bits wide, bit n holding the data of pin n.
// (R2) Every data bit clears to zero on reset and is readable and writable; port F reads return its synchronised pin levels, not its stored bits.
// (R3) Mode 00 gives the pin to another function; reads return stored data, writes leave the pin alone.
// (R4) Mode 01 drives the stored data bit onto the pin and reads return the stored data.
// (R5) Mode 10 enables the pull-up and reads return the pin level; writes store only.
// (R6) Mode 11 disables the pull-up and reads return the pin level; writes store only.
// (R7) Function and pull-up control come from per-port function control registers, not the data register.
// (R8) Pin 5 of port D never drives; code 01 must not be programmed and code 00 means no function.
// (R9) Port F has eight input-only pins whose pull-ups come from its own control register.
// (R10) Pin levels are read through a two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none

module gpio_ports
   import gpio_ports_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Ports A to E, bidirectional (bit 8*p+n is port p pin n)
   input  wire logic [39:0] port_pin_i,
   output logic      [39:0] port_pin_o,
   output logic      [39:0] port_pin_oe_o,
   output logic      [39:0] port_pullup_en_o,
   // Port F, input only
   input  wire logic [7:0]  port_f_pin_i,
   output logic      [7:0]  port_f_pullup_en_o
);

   // =======================================================================
   // Bus decode
   logic        req_d;
   logic        wr_d;
   logic [4:0]  data_wr_d;
   logic [4:0]  ctrl_wr_d;
   logic        f_data_wr_d;
   logic        f_ctrl_wr_d;
   logic [31:0] rdata_d;

   // A new request is taken only when no answer is outstanding
   assign req_d = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   assign wr_d  = req_d && wb_we_i;

   // Per-port write strobes for data (lane 0) and control (lanes 0 and 1, lane 0 only for port F)
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         data_wr_d[p] = wr_d && wb_sel_i[0]
                        && (wb_adr_i == PORT_A_PIN_DATA_OFS + 8'(p) * DATA_OFS_STEP);
         ctrl_wr_d[p] = wr_d
                        && (wb_adr_i == PORT_A_FUNCTION_CONTROL_OFS + 8'(p) * DATA_OFS_STEP);
      end
      f_data_wr_d = wr_d && wb_sel_i[0] && (wb_adr_i == PORT_F_PIN_DATA_OFS);
      f_ctrl_wr_d = wr_d && wb_sel_i[0] && (wb_adr_i == PORT_F_FUNCTION_CONTROL_OFS);
   end

   // =======================================================================
   // Function control registers
   logic [15:0] func_ctrl_q [5];
   logic [7:0]  f_pullup_ctrl_q;
   logic [7:0]  f_data_q;

   // Mode fields per port, written byte-lane by byte-lane
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int p = 0; p < 5; p++) begin
            func_ctrl_q[p] <= FUNC_CONTROL_RESET;
         end
      end else begin
         for (int p = 0; p < 5; p++) begin
            if (ctrl_wr_d[p] && wb_sel_i[0]) begin
               func_ctrl_q[p][7:0] <= wb_dat_i[7:0];     // see (R7)
            end
            if (ctrl_wr_d[p] && wb_sel_i[1]) begin
               func_ctrl_q[p][15:8] <= wb_dat_i[15:8];   // see (R7)
            end
         end
      end
   end

   // Port F pull-up enables, one bit per pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         f_pullup_ctrl_q <= PULLUP_CTRL_RESET;
      end else if (f_ctrl_wr_d) begin
         f_pullup_ctrl_q <= wb_dat_i[7:0];               // see (R9)
      end
   end

   // Port F stored data; reads always see the pin since it cannot drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         f_data_q <= PIN_DATA_RESET;                     // see (R2)
      end else if (f_data_wr_d) begin
         f_data_q <= wb_dat_i[7:0];
      end
   end

   // =======================================================================
   // Port slices A to E
   logic [7:0] slice_rdata [5];

   for (genvar p = 0; p < 5; p++) begin : g_port
      gpio_port_slice #(
         .OUT_ALLOWED ((p == RESTRICTED_PORT) ? 8'hDF : 8'hFF)   // see (R8)
      ) u_slice (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .ce_i        (ce_i),
         .wr_i        (data_wr_d[p]),
         .wdata_i     (wb_dat_i[7:0]),
         .mode_i      (func_ctrl_q[p]),
         .pin_i       (port_pin_i[8*p +: 8]),
         .rdata_o     (slice_rdata[p]),
         .pin_o       (port_pin_o[8*p +: 8]),
         .pin_oe_o    (port_pin_oe_o[8*p +: 8]),
         .pullup_en_o (port_pullup_en_o[8*p +: 8])
      );
   end

   // =======================================================================
   // Port F input path
   logic [7:0] f_sync1_q;
   logic [7:0] f_sync2_q;

   // Two-stage synchroniser for the input-only port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         f_sync1_q <= PIN_DATA_RESET;
         f_sync2_q <= PIN_DATA_RESET;
      end else if (ce_i) begin
         f_sync1_q <= port_f_pin_i;                      // see (R10)
         f_sync2_q <= f_sync1_q;
      end
   end

   // Pull-up drive for port F
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_f_pullup_en_o <= PULLUP_CTRL_RESET;
      end else if (ce_i) begin
         port_f_pullup_en_o <= f_pullup_ctrl_q;          // see (R9)
      end
   end

   // =======================================================================
   // Read mux
   always_comb begin
      rdata_d = UNMAPPED_READ;
      for (int p = 0; p < 5; p++) begin
         if (wb_adr_i == PORT_A_PIN_DATA_OFS + 8'(p) * DATA_OFS_STEP) begin
            rdata_d = {24'h00_0000, slice_rdata[p]};     // see (R3) see (R5)
         end
         if (wb_adr_i == PORT_A_FUNCTION_CONTROL_OFS + 8'(p) * DATA_OFS_STEP) begin
            rdata_d = {16'h0000, func_ctrl_q[p]};
         end
      end
      if (wb_adr_i == PORT_F_PIN_DATA_OFS) begin
         rdata_d = {24'h00_0000, f_sync2_q};             // see (R9)
      end
      if (wb_adr_i == PORT_F_FUNCTION_CONTROL_OFS) begin
         rdata_d = {24'h00_0000, f_pullup_ctrl_q};
      end
   end

   // Acknowledge one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= UNMAPPED_READ;
      end else if (ce_i) begin
         wb_ack_o <= req_d;
         if (req_d && !wb_we_i) begin
            wb_dat_o <= rdata_d;
         end
      end
   end

endmodule : gpio_ports

`default_nettype wire

// >>> gpio_ports_pkg.sv
/*
 * Package for the multi-port pin data register block: register offsets,
 * mode codes, field positions, reset values and bus widths.
 * Assumes a classic Wishbone slave with 32-bit data and byte addressing.
 */
`default_nettype none

package gpio_ports_pkg;

   // =======================================================================
   // Sizes
   localparam int unsigned PORT_WIDTH   = 8;
   localparam int unsigned NUM_IO_PORTS = 5;
   localparam int unsigned NUM_PORTS    = 6;
   localparam int unsigned ADDR_WIDTH   = 8;
   localparam int unsigned DATA_WIDTH   = 32;
   localparam int unsigned MODE_WIDTH   = 2 * PORT_WIDTH;

   // =======================================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] PORT_A_PIN_DATA_OFS         = 8'h00;
   localparam logic [7:0] PORT_B_PIN_DATA_OFS         = 8'h04;
   localparam logic [7:0] PORT_C_PIN_DATA_OFS         = 8'h08;
   localparam logic [7:0] PORT_D_PIN_DATA_OFS         = 8'h0C;
   localparam logic [7:0] PORT_E_PIN_DATA_OFS         = 8'h10;
   localparam logic [7:0] PORT_F_PIN_DATA_OFS         = 8'h14;
   localparam logic [7:0] PORT_A_FUNCTION_CONTROL_OFS = 8'h20;
   localparam logic [7:0] PORT_B_FUNCTION_CONTROL_OFS = 8'h24;
   localparam logic [7:0] PORT_C_FUNCTION_CONTROL_OFS = 8'h28;
   localparam logic [7:0] PORT_D_FUNCTION_CONTROL_OFS = 8'h2C;
   localparam logic [7:0] PORT_E_FUNCTION_CONTROL_OFS = 8'h30;
   localparam logic [7:0] PORT_F_FUNCTION_CONTROL_OFS = 8'h34;
   localparam logic [7:0] DATA_OFS_STEP               = 8'h04;

   // =======================================================================
   // Reset values
   localparam logic [7:0]  PIN_DATA_RESET     = 8'h00;
   localparam logic [15:0] FUNC_CONTROL_RESET = 16'h0000;
   localparam logic [7:0]  PULLUP_CTRL_RESET  = 8'h00;

   // =======================================================================
   // Per-pin mode codes (high bit, low bit)
   localparam logic [1:0] MODE_OTHER_FUNCTION = 2'b00;
   localparam logic [1:0] MODE_OUTPUT         = 2'b01;
   localparam logic [1:0] MODE_INPUT_PULLUP   = 2'b10;
   localparam logic [1:0] MODE_INPUT_NO_PULL  = 2'b11;

   // Restricted pin: pin 5 of port D has no output mode
   localparam int unsigned RESTRICTED_PORT = 3;
   localparam int unsigned RESTRICTED_PIN  = 5;

   // Unmapped reads return this value
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : gpio_ports_pkg

`default_nettype wire

// >>> gpio_ports_properties.sv
/* Port checker for gpio_ports: bus handshake, pin drive and reset relations.
   Assumes it is bound to gpio_ports; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_properties (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [39:0] port_pin_o,
   input wire logic [39:0] port_pin_oe_o,
   input wire logic [39:0] port_pullup_en_o,
   input wire logic [7:0]  port_f_pullup_en_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // =====================================================
   // Bus steps
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   // =====================================================
   // Properties
   property p_ack_pulse;
      s_req |=> s_ack_once;
   endproperty
   property p_unmapped;
      s_req ##0 (!wb_we_i && wb_adr_i == 8'h40) |=> wb_dat_o == 32'h0000_0000;
   endproperty
   property p_no_d5;
      port_pin_oe_o[29] == 1'b0;
   endproperty
   property p_excl;
      (port_pin_oe_o & port_pullup_en_o) == 40'h00_0000_0000;
   endproperty
   property p_oe_cause;
      $changed(port_pin_oe_o) |-> $past(wb_ack_o) && $past(wb_we_i);
   endproperty
   property p_pins_cause;
      $changed(port_pin_o) || $changed(port_pullup_en_o) |-> $past(wb_ack_o) && $past(wb_we_i);
   endproperty
   property p_f_cause;
      $changed(port_f_pullup_en_o) |-> $past(wb_ack_o) && $past(wb_we_i);
   endproperty
   property p_reset;
      disable iff (1'b0) rst_i |=> port_pin_oe_o == 40'h00_0000_0000 && port_pullup_en_o == 40'h00_0000_0000
         && port_pin_o == 40'h00_0000_0000 && port_f_pullup_en_o == 8'h00;
   endproperty

   a_ack_pulse: assert property (p_ack_pulse) else $error("ack is not one pulse");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_no_d5: assert property (p_no_d5) else $error("restricted pin drives");
   a_excl: assert property (p_excl) else $error("drive and pull-up together");
   a_oe_cause: assert property (p_oe_cause) else $error("drive changed without write");
   a_pins_cause: assert property (p_pins_cause) else $error("pin or pull changed without write");
   a_f_cause: assert property (p_f_cause) else $error("port F pull changed without write");
   a_reset: assert property (p_reset) else $error("outputs not clear after reset");
endmodule : gpio_ports_properties

bind gpio_ports gpio_ports_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o), .port_pullup_en_o(port_pullup_en_o),
   .port_f_pullup_en_o(port_f_pullup_en_o));

`default_nettype wire

// >>> pin_partner.sv
/* Model of the package pins: device drive, outside drive, pull-up, float.
   Assumes the bench never drives a pin that the device drives. */
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
   input  wire logic        clk_i,
   input  wire logic [39:0] pin_o_i,
   input  wire logic [39:0] oe_i,
   input  wire logic [39:0] pull_i,
   input  wire logic [39:0] ext_i,
   input  wire logic [39:0] drv_i,
   input  wire logic [7:0]  f_pull_i,
   input  wire logic [7:0]  f_ext_i,
   input  wire logic [7:0]  f_drv_i,
   output logic      [39:0] levels_o,
   output logic      [7:0]  f_levels_o
);
   logic tog_q = 1'b0;

   // A floating pin shows a changing level, never a held one
   always_ff @(posedge clk_i) tog_q <= ~tog_q;

   // Wire level per pin
   always_comb begin
      for (int n = 0; n < 40; n++) begin
         levels_o[n] = oe_i[n] ? pin_o_i[n] : drv_i[n] ? ext_i[n] : pull_i[n] ? 1'b1 : tog_q;
      end
      for (int n = 0; n < 8; n++) begin
         f_levels_o[n] = f_drv_i[n] ? f_ext_i[n] : f_pull_i[n] ? 1'b1 : tog_q;
      end
   end
endmodule : pin_partner

`default_nettype wire

// >>> tb_top.sv
/* Testbench for gpio_ports: bus tasks, scenarios and verdict.
   Assumes pin_partner for the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [39:0] pin_i, pin_o, oe, pull;
   logic [39:0] ext = 40'h00_0000_0000, drv = 40'hFF_FFFF_FFFF;
   logic [7:0]  f_pin, f_pull, f_ext = 8'h00, f_drv = 8'hFF;
   int          fail_count = 0, num_checks = 0;

   // Clock of 50 ns period
   initial forever #25 clk_i = ~clk_i;

   gpio_ports u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_pin_i(pin_i),
      .port_pin_o(pin_o), .port_pin_oe_o(oe), .port_pullup_en_o(pull), .port_f_pin_i(f_pin),
      .port_f_pullup_en_o(f_pull));
   pin_partner u_pins (.clk_i(clk_i), .pin_o_i(pin_o), .oe_i(oe), .pull_i(pull), .ext_i(ext), .drv_i(drv),
      .f_pull_i(f_pull), .f_ext_i(f_ext), .f_drv_i(f_drv), .levels_o(pin_i), .f_levels_o(f_pin));

   // =====================================================
   // Shared tasks
   task automatic results;
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                       output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      sel <= s;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      r = rdat;
      if (n == 20) chk(40'h1, 40'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      logic [31:0] r;
      xfer(1'b1, a, d, s, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 16'h0000, 4'hF, r);
      chk({8'h00, r}, {32'h0000_0000, e});
   endtask : rd

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset

   // =====================================================
   // Scenarios
   task automatic t_reset;
      for (int p = 0; p < 5; p++) begin
         rd(8'(4 * p), 8'h00);
         rd(8'(8'h20 + 4 * p), 8'h00);
      end
      chk(oe | pull | pin_o | {f_pull, 32'h0000_0000}, 40'h0);
   endtask : t_reset

   // Stores to all five ports, a lane-less write and an unmapped place
   task automatic t_data;
      for (int p = 0; p < 5; p++) wr(8'(4 * p), 16'h005A ^ 16'(p), 4'h1);
      for (int p = 0; p < 5; p++) rd(8'(4 * p), 8'h5A ^ 8'(p));
      wr(8'h00, 16'h00FF, 4'h0);
      rd(8'h00, 8'h5A);
      wr(8'h40, 16'h00FF, 4'h1);
      rd(8'h40, 8'h00);
      chk(oe, 40'h0);
   endtask : t_data

   // Every mode code on port B
   task automatic t_modes;
      for (int c = 0; c < 4; c++) begin
         drv[15:8] <= (c == 3) ? 8'hFF : 8'h00;
         ext[15:8] <= 8'h3C;
         wr(8'h24, {8{2'(c)}}, 4'h3);
         wr(8'h04, 16'h00A5, 4'h1);
         repeat (4) @(posedge clk_i);
         rd(8'h04, (c == 2) ? 8'hFF : (c == 3) ? 8'h3C : 8'hA5);
         chk({oe[15:8], pull[15:8], pin_o[15:8] & oe[15:8]},
             {(c == 1) ? 8'hFF : 8'h00, (c == 2) ? 8'hFF : 8'h00, (c == 1) ? 8'hA5 : 8'h00});
      end
   endtask : t_modes

   // Clock enable low freezes the port B input chain while its pins change
   task automatic t_freeze;
      ce <= 1'b0;
      ext[15:8] <= 8'hC3;
      repeat (4) @(posedge clk_i);
      ce <= 1'b1;
      rd(8'h04, 8'h3C);
      rd(8'h04, 8'hC3);
   endtask : t_freeze

   // Port D pin 5 is kept off code 01 by software; code 00 and input still work
   task automatic t_restricted;
      drv[31:24] <= 8'h00;
      wr(8'h0C, 16'h00FF, 4'h1);
      wr(8'h2C, 16'h5155, 4'h3);
      repeat (4) @(posedge clk_i);
      chk({32'h0000_0000, oe[31:24]}, 40'hDF);
      rd(8'h0C, 8'hFF);
      wr(8'h0C, 16'h0000, 4'h1);
      wr(8'h2C, 16'h0800, 4'h3);
      repeat (4) @(posedge clk_i);
      rd(8'h0C, 8'h20);
   endtask : t_restricted

   // Input-only port with pull-ups on the low half
   task automatic t_portf;
      f_drv <= 8'hF0;
      f_ext <= 8'hA5;
      wr(8'h34, 16'h000F, 4'h1);
      wr(8'h14, 16'h0000, 4'h1);
      repeat (4) @(posedge clk_i);
      chk({32'h0000_0000, f_pull}, 40'h0F);
      rd(8'h14, 8'hAF);
   endtask : t_portf

   // Main sequence, with a second reset after the last scenario and before the final reset check
   initial begin
      do_reset();
      t_reset();
      t_data();
      t_modes();
      t_freeze();
      t_restricted();
      t_portf();
      do_reset();
      t_reset();
      results();
   end

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      results();
   end
endmodule : tb_top

`default_nettype wire
